// *** common/pgrf_pkg.sv ***
// Purpose: Constants and types of the power-good/ramp/fault config bank
// Assumes: 50 MHz reference clock, two outputs (pages)
// Notes:   Notes on behaviour list below
// Notes on behaviour
// - Power-good waits programmed delay, 0-500 ms, 125 ns.
// - Delay is linear-11 milliseconds, default 1 ms.
// - Ramp gain one shared byte, resets to 3.
// - Smaller gain lengthens rise, larger shortens it.
// - Four-phase group selects multiphase ramp mode.
// - Fast loop off in multiphase ramp, on after power-good.
// - Multiphase mode skips soft-off and fall time.
// - Multiphase shutdown tri-states high side, low low.
// - Standalone keeps fast loop and normal ramps.
// - Inductor linear-11 microhenries, default 0.3 uH.
// - Set mask bit blocks that fault's capture.
// - Mask bits 13..10 spread, phase, cpu, crc.
// - Mask bits 7..0 current, input, temp, vout.
// - Config bit 7 turns low side on for OV.
// - Fault declared after N+1 consecutive violations.
// - Config resets to zero, bits 6:4 unused.
// - Power-good open drain or push-pull per bit.
package pgrf_pkg;

  // Command codes
  localparam logic [7:0]  CMD_PG_DELAY   = 8'hd4;
  localparam logic [7:0]  CMD_RAMP_GAIN  = 8'hd5;
  localparam logic [7:0]  CMD_INDUCTOR   = 8'hd6;
  localparam logic [7:0]  CMD_CAP_MASK   = 8'hd7;
  localparam logic [7:0]  CMD_VF_CONFIG  = 8'hd8;

  // Reset values
  localparam logic [15:0] RST_PG_DELAY   = 16'hba00;
  localparam logic [7:0]  RST_RAMP_GAIN  = 8'h03;
  localparam logic [15:0] RST_INDUCTOR   = 16'hb133;
  localparam logic [15:0] RST_CAP_MASK   = 16'h0000;
  localparam logic [7:0]  RST_VF_CONFIG  = 8'h00;

  // Field layout
  localparam int          VF_LS_ON_BIT   = 7;
  localparam int          VF_CNT_MSB     = 3;
  localparam logic [7:0]  VF_USED_MASK   = 8'h8f;
  localparam logic [15:0] CAP_USED_MASK  = 16'h3cff;
  localparam int          L11_EXP_LSB    = 11;
  localparam logic [2:0]  PHASES_FOUR    = 3'h3;

  // Timing
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          PG_STEP_NS     = 125;
  localparam int          PG_MAX_MS      = 500;
  localparam int          STEPS_PER_MS   = 1000000 / PG_STEP_NS;
  localparam int          PG_MAX_STEPS   = PG_MAX_MS * STEPS_PER_MS;

  // Power-good state per output
  typedef enum logic [2:0] {
    PG_LOW  = 3'b001,
    PG_WAIT = 3'b010,
    PG_HIGH = 3'b100
  } pgrf_pg_e;

  // Command request from the bus front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        page;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pgrf_cmd_s;

  // Register read answer
  typedef struct packed {
    logic        ack;
    logic        unmapped;
    logic [15:0] data;
  } pgrf_rsp_s;

endpackage : pgrf_pkg

// *** hdl/pgrf_config_bank.sv ***
// Purpose: Power-good delay, ramp gain, inductor, capture mask, OV/UV config
// Assumes: Command layer already decoded; samples come from same clock
// Notes:   One page per output; gain and mask are global
`timescale 1ns/100ps
`default_nettype none

module pgrf_config_bank #(
  parameter int N_OUT = 2                       // Outputs (pages)
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Command port
  input  wire pgrf_pkg::pgrf_cmd_s   i_cmd,
  output var  pgrf_pkg::pgrf_rsp_s   o_rsp,
  // System configuration (same clock)
  input  wire logic [2:0]            i_phases_in_rail,
  input  wire logic                  i_pg_push_pull,
  // Per-output analog status (asynchronous pins)
  input  wire logic [N_OUT-1:0]      i_above_pg_thr,
  // Per-output monitor samples (same clock)
  input  wire logic [N_OUT-1:0]      i_sample_stb,
  input  wire logic [N_OUT-1:0]      i_ov_violation,
  input  wire logic [N_OUT-1:0]      i_uv_violation,
  input  wire logic [N_OUT-1:0]      i_shutdown,
  // Fault events for snapshot capture
  input  wire logic [15:0]           i_fault_events,
  // Power-good pin
  output logic      [N_OUT-1:0]      o_power_ok_pin_o,
  output logic      [N_OUT-1:0]      o_power_ok_pin_oe,
  // Control towards the loop and drivers
  output logic      [7:0]            o_ramp_gain,
  output logic                       o_multiphase_mode,
  output logic      [N_OUT-1:0]      o_adaptive_fast_loop,
  output logic      [N_OUT-1:0]      o_soft_off_allowed,
  output logic      [N_OUT-1:0]      o_high_side_tristate,
  output logic      [N_OUT-1:0]      o_low_side_force_low,
  output logic      [N_OUT-1:0]      o_low_side_on,
  output logic      [N_OUT-1:0]      o_out_voltage_high_fault,
  output logic      [N_OUT-1:0]      o_out_voltage_low_fault,
  output logic      [N_OUT*16-1:0]   o_inductor_value,
  output logic                       o_snapshot_req
);

  ////////////////////////////////////////////////////////////////////////
  // Global registers and decode

  logic [7:0]  ramp_gain_reg;                   // Shared ramp gain
  logic [15:0] cap_mask_reg;                    // Snapshot fault mask
  logic        mp_mode_reg;                     // Multiphase ramp mode
  logic        snap_reg;                        // Snapshot request
  pgrf_pkg::pgrf_rsp_s rsp_reg;                 // Read answer

  // One select per command code
  wire sel_gain = i_cmd.code == pgrf_pkg::CMD_RAMP_GAIN;
  wire sel_mask = i_cmd.code == pgrf_pkg::CMD_CAP_MASK;
  wire sel_dly  = i_cmd.code == pgrf_pkg::CMD_PG_DELAY;
  wire sel_ind  = i_cmd.code == pgrf_pkg::CMD_INDUCTOR;
  wire sel_vf   = i_cmd.code == pgrf_pkg::CMD_VF_CONFIG;
  wire mapped   = sel_gain | sel_mask | sel_dly | sel_ind | sel_vf;

  // Four-phase group forces multiphase ramp; two-phase is standalone
  wire mp_next  = i_phases_in_rail == pgrf_pkg::PHASES_FOUR;

  // Unmasked, used fault types raise a capture request
  wire [15:0] snap_hits = i_fault_events & ~cap_mask_reg
                          & pgrf_pkg::CAP_USED_MASK;

  // Full byte range kept; the ramp engine scales rise time by 1/gain
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ramp_gain_reg <= pgrf_pkg::RST_RAMP_GAIN;
      cap_mask_reg  <= pgrf_pkg::RST_CAP_MASK;
      mp_mode_reg   <= 1'b0;
      snap_reg      <= 1'b0;
    end else begin
      if (i_cmd.wr && sel_gain) begin
        ramp_gain_reg <= i_cmd.wdata[7:0];
      end
      if (i_cmd.wr && sel_mask) begin
        cap_mask_reg  <= i_cmd.wdata;
      end
      // Mode tracks the phase count
      mp_mode_reg   <= mp_next;
      snap_reg      <= |snap_hits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-output registers and logic

  // Per-page words flattened for read-back
  logic [N_OUT*16-1:0] dly_all;                 // Delay words, flat
  logic [N_OUT*8-1:0]  vf_all;                  // Fault configs, flat

  // Fractional 125 ns step: advance by the clock period, wrap at step
  logic [7:0] step_acc_reg;                     // Sub-step accumulator
  logic       step_reg;                         // One-cycle step tick
  wire  [7:0] acc_sum = step_acc_reg + 8'(pgrf_pkg::CLK_PERIOD_NS);
  wire        acc_wrap = acc_sum >= 8'(pgrf_pkg::PG_STEP_NS);

  // Step tick shared by both outputs' delay timers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_acc_reg <= 8'h00;
      step_reg     <= 1'b0;
    end else begin
      // Remainder kept so the mean step is exact
      step_acc_reg <= acc_wrap ?
                      acc_sum - 8'(pgrf_pkg::PG_STEP_NS) : acc_sum;
      step_reg     <= acc_wrap;
    end
  end

  // Linear-11 milliseconds to 125 ns steps, clamped to 500 ms
  function automatic logic [31:0] ms_to_steps(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic        [47:0] p;
    // Signed exponent and mantissa
    e = w[15:pgrf_pkg::L11_EXP_LSB];
    m = w[10:0];
    p = 48'(pgrf_pkg::STEPS_PER_MS);
    if (m < 0) begin
      p = 48'h0;                                // Negative time: none
    end else begin
      p = p * 48'(m);
      p = (e < 0) ? (p >> (-e)) : (p << e);
    end
    if (p > 48'(pgrf_pkg::PG_MAX_STEPS)) begin
      p = 48'(pgrf_pkg::PG_MAX_STEPS);
    end
    ms_to_steps = p[31:0];
  endfunction : ms_to_steps

  // One slice per output page
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      logic [15:0] dly_reg;                     // Power-good delay word
      logic [15:0] ind_reg;                     // Inductor value word
      logic [7:0]  vf_reg;                      // Voltage fault config
      logic [1:0]  thr_sync_reg;                // Threshold synchroniser
      logic [31:0] pg_cnt_reg;                  // Delay steps elapsed
      pgrf_pkg::pgrf_pg_e pg_st_reg;            // Power-good state
      pgrf_pkg::pgrf_pg_e pg_st_next;
      logic [3:0]  ov_cnt_reg;                  // OV run length
      logic [3:0]  uv_cnt_reg;                  // UV run length
      logic        ov_flt_reg;                  // OV fault latched
      logic        uv_flt_reg;                  // UV fault latched
      logic        pg_out_reg;                  // Power-good pin data
      logic        pg_oe_reg;                   // Power-good pin enable
      logic        fast_reg;                    // Fast loop enable
      logic        soft_reg;                    // Soft-off allowed
      logic        hs_tri_reg;                  // High side tri-state
      logic        ls_low_reg;                  // Low side forced low
      logic        ls_on_reg;                   // Low side on for OV

      // Page decode and status terms
      wire wr_pg    = i_cmd.wr && (i_cmd.page == g);
      wire above    = thr_sync_reg[1];
      wire [31:0] target = ms_to_steps(dly_reg);
      wire dly_done = pg_cnt_reg >= target;
      wire [3:0] lim = vf_reg[pgrf_pkg::VF_CNT_MSB:0];
      wire ov_hit   = i_sample_stb[g] && i_ov_violation[g];
      wire uv_hit   = i_sample_stb[g] && i_uv_violation[g];
      wire pg_on    = pg_st_reg == pgrf_pkg::PG_HIGH;

      // Register writes for this page
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          dly_reg <= pgrf_pkg::RST_PG_DELAY;
          ind_reg <= pgrf_pkg::RST_INDUCTOR;
          vf_reg  <= pgrf_pkg::RST_VF_CONFIG;
        end else begin
          if (wr_pg && sel_dly) begin
            dly_reg <= i_cmd.wdata;
          end
          if (wr_pg && sel_ind) begin
            ind_reg <= i_cmd.wdata;
          end
          // Unused config bits always read zero
          if (wr_pg && sel_vf) begin
            vf_reg  <= i_cmd.wdata[7:0] & pgrf_pkg::VF_USED_MASK;
          end
        end
      end

      // Pin synchroniser, second stage only is read
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          thr_sync_reg <= 2'b00;
        end else begin
          thr_sync_reg <= {thr_sync_reg[0], i_above_pg_thr[g]};
        end
      end

      // Power-good sequencing; any dip restarts the wait
      always_comb begin
        case (pg_st_reg)
          pgrf_pkg::PG_LOW: begin
            pg_st_next = above ? pgrf_pkg::PG_WAIT : pgrf_pkg::PG_LOW;
          end
          pgrf_pkg::PG_WAIT: begin
            if (!above) begin
              pg_st_next = pgrf_pkg::PG_LOW;
            end else if (dly_done) begin
              pg_st_next = pgrf_pkg::PG_HIGH;
            end else begin
              pg_st_next = pgrf_pkg::PG_WAIT;
            end
          end
          pgrf_pkg::PG_HIGH: begin
            pg_st_next = above ? pgrf_pkg::PG_HIGH : pgrf_pkg::PG_LOW;
          end
          default: begin
            pg_st_next = pgrf_pkg::PG_LOW;
          end
        endcase
      end

      // Delay counter runs only while waiting uninterrupted
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pg_st_reg  <= pgrf_pkg::PG_LOW;
          pg_cnt_reg <= 32'h0;
        end else begin
          pg_st_reg  <= pg_st_next;
          if (pg_st_next != pgrf_pkg::PG_WAIT) begin
            pg_cnt_reg <= 32'h0;
          end else if (step_reg) begin
            pg_cnt_reg <= pg_cnt_reg + 32'h1;
          end
        end
      end

      // Consecutive violation counters; an in-limit sample clears them
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ov_cnt_reg <= 4'h0;
          uv_cnt_reg <= 4'h0;
          ov_flt_reg <= 1'b0;
          uv_flt_reg <= 1'b0;
        end else if (i_sample_stb[g]) begin
          // Saturate at the limit so a long run stays declared
          if (!ov_hit) begin
            ov_cnt_reg <= 4'h0;
          end else if (ov_cnt_reg < lim) begin
            ov_cnt_reg <= ov_cnt_reg + 4'h1;
          end
          if (!uv_hit) begin
            uv_cnt_reg <= 4'h0;
          end else if (uv_cnt_reg < lim) begin
            uv_cnt_reg <= uv_cnt_reg + 4'h1;
          end
          // Latched until the output is shut down
          if (ov_hit && ov_cnt_reg == lim) begin
            ov_flt_reg <= 1'b1;
          end
          if (uv_hit && uv_cnt_reg == lim) begin
            uv_flt_reg <= 1'b1;
          end
        // A strobe wins over shutdown, so no event is lost
        end else if (i_shutdown[g] && !ov_hit && !uv_hit) begin
          ov_flt_reg <= 1'b0;
          uv_flt_reg <= 1'b0;
        end
      end

      // Pin drive and loop/driver controls
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pg_out_reg <= 1'b0;
          pg_oe_reg  <= 1'b1;
          fast_reg   <= 1'b1;
          soft_reg   <= 1'b1;
          hs_tri_reg <= 1'b0;
          ls_low_reg <= 1'b0;
          ls_on_reg  <= 1'b0;
        end else begin
          // Open drain drives only the low level
          pg_out_reg <= pg_on;
          pg_oe_reg  <= i_pg_push_pull | ~pg_on;
          // Fast loop held off during a multiphase ramp
          fast_reg   <= ~mp_mode_reg | pg_on;
          soft_reg   <= ~mp_mode_reg;
          hs_tri_reg <= mp_mode_reg & i_shutdown[g];
          ls_low_reg <= mp_mode_reg & i_shutdown[g];
          ls_on_reg  <= ov_flt_reg & vf_reg[pgrf_pkg::VF_LS_ON_BIT];
        end
      end

      // Flops straight to ports and read buses
      assign dly_all[g*16 +: 16]          = dly_reg;
      assign vf_all[g*8 +: 8]             = vf_reg;
      assign o_inductor_value[g*16 +: 16] = ind_reg;
      assign o_power_ok_pin_o[g]          = pg_out_reg;
      assign o_power_ok_pin_oe[g]         = pg_oe_reg;
      assign o_adaptive_fast_loop[g]      = fast_reg;
      assign o_soft_off_allowed[g]        = soft_reg;
      assign o_high_side_tristate[g]      = hs_tri_reg;
      assign o_low_side_force_low[g]      = ls_low_reg;
      assign o_low_side_on[g]             = ls_on_reg;
      assign o_out_voltage_high_fault[g]  = ov_flt_reg;
      assign o_out_voltage_low_fault[g]   = uv_flt_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Unknown codes read as zero
  wire [15:0] ind_sel = o_inductor_value[i_cmd.page*16 +: 16];
  wire [15:0] dly_sel = dly_all[i_cmd.page*16 +: 16];
  wire [7:0]  vf_sel  = vf_all[i_cmd.page*8 +: 8];
  wire [15:0] rd_mux  = sel_gain ? {8'h00, ramp_gain_reg} :
                        sel_mask ? cap_mask_reg :
                        sel_dly  ? dly_sel :
                        sel_ind  ? ind_sel :
                        sel_vf   ? {8'h00, vf_sel} : 16'h0000;

  // Answer one cycle after the read request
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack      <= i_cmd.rd;
      rsp_reg.unmapped <= i_cmd.rd & ~mapped;
      rsp_reg.data     <= i_cmd.rd ? rd_mux : 16'h0000;
    end
  end

  // Global outputs, each from a flop
  assign o_rsp             = rsp_reg;
  assign o_ramp_gain       = ramp_gain_reg;
  assign o_multiphase_mode = mp_mode_reg;
  assign o_snapshot_req    = snap_reg;

endmodule : pgrf_config_bank

`default_nettype wire

// *** tb/pgrf_config_bank_sva.sv ***
// Purpose: Port assertions for the config bank
// Assumes: One clock domain, reset low during start-up
// Notes:   Bound to every bank instance
`timescale 1ns/100ps
`default_nettype none

module pgrf_chk #(
  parameter int N_OUT = 2                       // Outputs (pages)
) (
  // Clock, reset and command port
  input wire logic                i_ref_clk,
  input wire logic                i_rst_n,
  input wire pgrf_pkg::pgrf_cmd_s i_cmd,
  input wire pgrf_pkg::pgrf_rsp_s o_rsp,
  // System inputs
  input wire logic [2:0]          i_phases_in_rail,
  input wire logic [N_OUT-1:0]    i_above_pg_thr,
  input wire logic [N_OUT-1:0]    i_sample_stb,
  input wire logic [N_OUT-1:0]    i_ov_violation,
  input wire logic [N_OUT-1:0]    i_shutdown,
  input wire logic [15:0]         i_fault_events,
  // Observed outputs
  input wire logic [N_OUT-1:0]    o_power_ok_pin_o,
  input wire logic                o_multiphase_mode,
  input wire logic [N_OUT-1:0]    o_adaptive_fast_loop,
  input wire logic [N_OUT-1:0]    o_high_side_tristate,
  input wire logic [N_OUT-1:0]    o_low_side_force_low,
  input wire logic [N_OUT-1:0]    o_low_side_on,
  input wire logic [N_OUT-1:0]    o_out_voltage_high_fault,
  input wire logic                o_snapshot_req
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Register port: exactly one answer per read
  chk_read_answer: assert property (i_cmd.rd |=> o_rsp.ack)
    else $error("read not answered in one cycle");
  chk_ack_cause: assert property (o_rsp.ack |-> $past(i_cmd.rd))
    else $error("answer without a read");
  chk_unmapped_zero: assert property (o_rsp.unmapped
    |-> o_rsp.data == 0)
    else $error("unmapped read returned data");

  ////////////////////////////////////////////////////////////////////////////
  // Ramp mode and shutdown drive
  chk_mp_cause: assert property ($rose(o_multiphase_mode)
    |-> $past(i_phases_in_rail) == 3'h3)
    else $error("multiphase mode without four phases");
  chk_fast_standalone: assert property (!o_multiphase_mode
    && !$past(o_multiphase_mode) |-> &o_adaptive_fast_loop)
    else $error("fast loop off in standalone");
  chk_drive_pair: assert property (o_high_side_tristate ==
    ($past(i_shutdown) & {N_OUT{$past(o_multiphase_mode)}})
    && o_low_side_force_low == o_high_side_tristate)
    else $error("shutdown drive not from mode and shutdown");

  ////////////////////////////////////////////////////////////////////////////
  // Capture and faults: an output needs its cause
  chk_snap_cause: assert property (!$past(|(i_fault_events & 16'h3cff))
    |-> !o_snapshot_req)
    else $error("capture without a fault event");
  chk_ov_cause: assert property ($rose(o_out_voltage_high_fault[0])
    |-> $past(i_sample_stb[0] && i_ov_violation[0]))
    else $error("overvoltage fault without violation");
  chk_ls_cause: assert property ((o_low_side_on
    & ~$past(o_out_voltage_high_fault)) == '0)
    else $error("low side on without overvoltage fault");

  ////////////////////////////////////////////////////////////////////////////
  // Power-good follows the threshold, never ahead of it
  chk_pg_cause: assert property ($rose(o_power_ok_pin_o[0])
    |-> $past(i_above_pg_thr[0], 5) && $past(i_above_pg_thr[0], 4))
    else $error("power good ahead of threshold");
  chk_pg_drop: assert property (!i_above_pg_thr[0] [*6]
    |=> !o_power_ok_pin_o[0])
    else $error("power good held below threshold");

  // Main scenarios reached
  cov_read: cover property (i_cmd.rd ##1 o_rsp.ack);
  cov_mp: cover property ($rose(o_multiphase_mode));
  cov_ov: cover property ($rose(o_out_voltage_high_fault[0]));
endmodule : pgrf_chk

bind pgrf_config_bank pgrf_chk #(.N_OUT(N_OUT)) chk_u (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .o_rsp(o_rsp),
  .i_phases_in_rail(i_phases_in_rail), .i_above_pg_thr(i_above_pg_thr),
  .i_sample_stb(i_sample_stb), .i_ov_violation(i_ov_violation),
  .i_fault_events(i_fault_events), .o_power_ok_pin_o(o_power_ok_pin_o),
  .o_multiphase_mode(o_multiphase_mode),
  .o_adaptive_fast_loop(o_adaptive_fast_loop),
  .o_high_side_tristate(o_high_side_tristate),
  .o_low_side_force_low(o_low_side_force_low),
  .o_low_side_on(o_low_side_on), .i_shutdown(i_shutdown),
  .o_out_voltage_high_fault(o_out_voltage_high_fault),
  .o_snapshot_req(o_snapshot_req));
`default_nettype wire

// *** tb/pgrf_host_model.sv ***
// Purpose: Command host that writes and reads the bank
// Assumes: Strobes change just after a rising edge
// Notes:   Idle fields carry inverted values so nothing leans on them
`timescale 1ns/100ps
`default_nettype none

module pgrf_host_model (
  // Clock
  input  wire logic                i_ref_clk,
  // Command link
  output var  pgrf_pkg::pgrf_cmd_s o_cmd,
  input  wire pgrf_pkg::pgrf_rsp_s i_rsp
);
  initial o_cmd = '0;

  // One write, taken at the edge after it is raised
  task automatic wr(input logic p, input logic [7:0] c,
                    input logic [15:0] d);
    @(posedge i_ref_clk);
    o_cmd <= '{1'b1, 1'b0, p, c, d};
    @(posedge i_ref_clk);
    o_cmd <= '{1'b0, 1'b0, ~p, ~c, ~d};
  endtask : wr

  // One read; answer sampled one edge after the taking edge
  task automatic rd(input logic p, input logic [7:0] c,
                    output logic [15:0] d, output logic u);
    @(posedge i_ref_clk);
    o_cmd <= '{1'b0, 1'b1, p, c, 16'h0000};
    @(posedge i_ref_clk);
    o_cmd <= '{1'b0, 1'b0, ~p, ~c, 16'hffff};
    @(posedge i_ref_clk);
    // No answer gives unknown data, so any compare fails
    d = (i_rsp.ack === 1'b1) ? i_rsp.data : 'x;
    u = i_rsp.unmapped;
  endtask : rd
endmodule : pgrf_host_model
`default_nettype wire

// *** tb/pgrf_config_bank_bench.sv ***
// Purpose: Self-checking bench for the config bank
// Assumes: 50 MHz clock, host model on the command port
// Notes:   Short power-good delays keep the run brief
`timescale 1ns/100ps
`default_nettype none

module pgrf_config_bank_bench;
  logic                i_ref_clk;
  logic                i_rst_n = 1'b0;
  pgrf_pkg::pgrf_cmd_s cmd;
  pgrf_pkg::pgrf_rsp_s rsp;
  logic [2:0]          phases = 3'h0;
  logic                pp = 1'b0;
  logic [1:0]          thr = 2'h0, stb = 2'h0, ov = 2'h0, uv = 2'h0;
  logic [1:0]          sd = 2'h0, pg_o, pg_oe, fl, so, ts, flow, lson;
  logic [1:0]          ovf, uvf;
  logic [15:0]         ev = 16'h0000, w, d;
  logic [7:0]          gain, c;
  logic [31:0]         ind;
  logic                mp, snap, u, p;
  int                  mismatches = 0, tests_run = 0, k, n, e;
  integer              seed = 32'hf29acc43;
  // Expected register contents, [command][page]
  logic [15:0]         sh [0:4][0:1] = '{'{16'hba00, 16'hba00},
    '{16'h0003, 16'h0003}, '{16'hb133, 16'hb133}, '{2{16'h0000}},
    '{2{16'h0000}}};

  pgrf_host_model host_u (.i_ref_clk(i_ref_clk), .o_cmd(cmd), .i_rsp(rsp));
  pgrf_config_bank #(.N_OUT(2)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .o_rsp(rsp),
    .i_phases_in_rail(phases), .i_pg_push_pull(pp), .i_above_pg_thr(thr),
    .i_sample_stb(stb), .i_ov_violation(ov), .i_uv_violation(uv),
    .i_shutdown(sd), .i_fault_events(ev), .o_power_ok_pin_o(pg_o),
    .o_power_ok_pin_oe(pg_oe), .o_ramp_gain(gain),
    .o_multiphase_mode(mp), .o_adaptive_fast_loop(fl),
    .o_soft_off_allowed(so), .o_high_side_tristate(ts),
    .o_low_side_force_low(flow), .o_low_side_on(lson),
    .o_out_voltage_high_fault(ovf), .o_out_voltage_low_fault(uvf),
    .o_inductor_value(ind), .o_snapshot_req(snap));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs about 66k cycles
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #(90000 * 20);
    mismatches++;
    end_of_test();
  end

  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // Expectations: stored value of a write, power-good latency
  function automatic logic [15:0] fit(logic [7:0] cc, logic [15:0] v);
    if (cc == 8'hd5) return {8'h00, v[7:0]};
    if (cc == 8'hd8) return {8'h00, v[7:0] & 8'h8f};
    return v;
  endfunction : fit
  function automatic int pg_cyc(logic [15:0] v);
    int ex;
    int m;
    ex = $signed(v[15:11]);
    m = $signed(v[10:0]);
    if (m < 0) return 4;
    m = (ex < 0) ? (m * 8000) >>> -ex : (m * 8000) << ex;
    return m * 125 / 20 + 4;
  endfunction : pg_cyc

  // Write and track; gain and mask are shared by both pages
  task automatic wr_sh(logic pg, logic [7:0] cc, logic [15:0] v);
    host_u.wr(pg, cc, v);
    if (cc >= 8'hd4 && cc <= 8'hd8) begin
      sh[cc - 8'hd4][pg] = fit(cc, v);
      if (cc == 8'hd5 || cc == 8'hd7) sh[cc - 8'hd4][!pg] = fit(cc, v);
    end
  endtask : wr_sh
  task automatic rd_all();
    for (int i = 0; i < 10; i++) begin
      host_u.rd(i[0], 8'hd4 + i[3:1], d, u);
      check("register", {u, d}, {1'b0, sh[i / 2][i % 2]});
    end
  endtask : rd_all
  task automatic samp(logic o, logic v);
    @(posedge i_ref_clk);
    {stb[0], ov[0], uv[0]} <= {1'b1, o, v};
    @(posedge i_ref_clk);
    stb[0] <= 1'b0;
  endtask : samp
  task automatic pg_wait(int g, logic [15:0] v);
    n = 0;
    while (pg_o[g] !== 1'b1 && n < 60000) begin
      @(posedge i_ref_clk);
      n++;
    end
    e = pg_cyc(v);
    check("pg_delay", n >= e - 7 && n <= e + 7, 1);
  endtask : pg_wait

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd_all();
    // Corners, random traffic, an unmapped code
    wr_sh(1, 8'hd5, 16'h12ff);
    wr_sh(0, 8'hd8, 16'hffff);
    for (k = 0; k < 12; k++) begin
      c = (k == 11) ? 8'hd9 : 8'hd4 + 8'($unsigned($random(seed)) % 5);
      p = $random(seed);
      wr_sh(p, c, $random(seed));
    end
    host_u.rd(0, 8'hd9, d, u);
    check("unmapped", {u, d}, {1'b1, 16'h0000});
    rd_all();
    check("gain", gain, sh[1][0]);
    check("inductor", ind, {sh[2][1], sh[2][0]});
    // Capture mask: walk each fault type
    for (k = 0; k < 16; k++) begin
      w = (k == 0) ? 16'hffff : $random(seed);
      wr_sh(0, 8'hd7, w);
      ev <= 16'h0001 << k;
      repeat (3) @(posedge i_ref_clk);
      check("snap", snap, |((16'h0001 << k) & ~w & 16'h3cff));
    end
    // Violation runs: short of N+1, broken, then complete
    for (k = 0; k < 4; k++) begin
      n = (k == 0) ? 0 : 1 + $unsigned($random(seed)) % 15;
      wr_sh(0, 8'hd8, {8'h00, k[0], 3'b111, n[3:0]});
      repeat (n) samp(k < 2, k >= 2);
      samp(0, 0);
      repeat (n) samp(k < 2, k >= 2);
      repeat (3) @(posedge i_ref_clk);
      check("no_fault", {ovf[0], uvf[0]}, 0);
      samp(k < 2, k >= 2);
      repeat (3) @(posedge i_ref_clk);
      check("fault", {ovf[0], uvf[0]}, {k < 2, k >= 2});
      check("low_side", lson[0], k == 1);
      sd[0] <= 1'b1;
      samp(0, 0);
      sd[0] <= 1'b0;
    end
    // Four-phase group with page 1 shut down
    phases <= 3'h3;
    sd[1] <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    check("mp_shut", {mp, ts, flow, so[1], fl[0]}, 7'b1101000);
    wr_sh(0, 8'hd4, 16'he801);
    pp <= 1'b1;
    thr[0] <= 1'b1;
    pg_wait(0, 16'he801);
    repeat (3) @(posedge i_ref_clk);
    check("pg_on", {fl[0], pg_oe[0]}, 2'b11);
    // A dip restarts the whole delay
    thr[0] <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    thr[0] <= 1'b1;
    repeat (3000) @(posedge i_ref_clk);
    thr[0] <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    thr[0] <= 1'b1;
    pg_wait(0, 16'he801);
    pp <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check("open_drain", {pg_o[0], pg_oe[0]}, 2'b10);
    wr_sh(1, 8'hd4, 16'h0000);
    thr[1] <= 1'b1;
    pg_wait(1, 16'h0000);
    thr[1] <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    wr_sh(1, 8'hd4, 16'hba00);
    thr[1] <= 1'b1;
    pg_wait(1, 16'hba00);
    // Two phases: standalone, everything normal
    phases <= 3'h1;
    repeat (4) @(posedge i_ref_clk);
    check("standalone", {mp, ts, fl, so}, 7'b0001111);
    end_of_test();
  end
endmodule : pgrf_config_bank_bench
`default_nettype wire
